//--- common/fws_cfg.svh
// constants for the flash status-polling controller
`ifndef FWS_CFG_SVH
`define FWS_CFG_SVH
`define FWS_ADR_CTRL     2'h0
`define FWS_ADR_ADDR     2'h1
`define FWS_ADR_STAT     2'h2
`define FWS_ADR_MASK     2'h3
`define FWS_CTRL_POLL    0
`define FWS_CTRL_RST     1
`define FWS_CTRL_ERSW    2
`define FWS_BIT_EWIN     3
`define FWS_BIT_TLIM     5
`define FWS_BIT_MTOG     6
`define FWS_BIT_DPOL     7
`define FWS_BIT_STOG     2
`define FWS_RST_CMD      16'h00F0
`define FWS_RD_CYC       4'h6
`define FWS_WR_CYC       4'h6
`define FWS_GAP_CYC      4'h2
`define FWS_EV_DONE      0
`define FWS_EV_FAIL      1
`define FWS_EV_REJ       2
`endif

//--- common/fws_pkg.sv
// types for the flash status-polling controller
package fws_pkg;
   typedef enum logic [3:0] {
      FWS_IDLE, FWS_RD1, FWS_RD2, FWS_CHK, FWS_RD3, FWS_RD4, FWS_CHK2,
      FWS_RST, FWS_EW1, FWS_EW2, FWS_EW3, FWS_EWCHK
   } fws_state_t;
endpackage : fws_pkg

//--- logic/fws_bus_cycle.sv
// single flash bus cycle engine: read or write with strobe timing
`include "fws_cfg.svh"
module fws_bus_cycle #(
   parameter int AW = 23,
   parameter int DW = 16
) (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          start_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] addr_i,
   input  wire logic [DW-1:0] wdata_i,
   input  wire logic [DW-1:0] fl_dq_i,
   output logic               busy_o,
   output logic               done_o,
   output logic [DW-1:0]      rdata_o,
   output logic [AW-1:0]      fl_addr_o,
   output logic [DW-1:0]      fl_dq_o,
   output logic               fl_dq_oe_o,
   output logic               fl_ce_n_o,
   output logic               fl_oe_n_o,
   output logic               fl_we_n_o
);
   typedef struct packed {
      logic          act;
      logic          we;
      logic [3:0]    cnt;
      logic          gap;
      logic          done;
      logic [DW-1:0] rdata;
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
   } fws_cyc_t;
   fws_cyc_t s, next_s;
   // three-stage sampler on the data pins; second and third agree
   logic [DW-1:0] dq1, dq2, dq3;
   always_ff @(posedge clk_i) begin
      dq1 <= fl_dq_i;
      dq2 <= dq1;
      dq3 <= dq2;
   end
   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      if (s.act) begin
         if (s.cnt != 4'h0) begin
            next_s.cnt = s.cnt - 4'h1;
         end else begin
            // gap keeps each read a distinct strobe so the toggle advances
            if (!s.we && dq2 == dq3) next_s.rdata = dq3;
            next_s.act = 1'b0;
            next_s.gap = 1'b1;
            next_s.cnt = `FWS_GAP_CYC;
            next_s.done = 1'b1;
         end
      end else if (s.gap) begin
         if (s.cnt != 4'h0) next_s.cnt = s.cnt - 4'h1;
         else next_s.gap = 1'b0;
      end else if (start_i) begin
         next_s.act = 1'b1;
         next_s.we = we_i;
         next_s.addr = addr_i;
         next_s.wdata = wdata_i;
         next_s.cnt = we_i ? `FWS_WR_CYC : `FWS_RD_CYC;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) s <= '0;
      else s <= next_s;
   end
   assign busy_o = s.act | s.gap;
   assign done_o = s.done;
   assign rdata_o = s.rdata;
   assign fl_addr_o = s.addr;
   assign fl_dq_o = s.wdata;
   assign fl_dq_oe_o = s.act & s.we;
   assign fl_ce_n_o = ~s.act;
   assign fl_oe_n_o = ~(s.act & ~s.we);
   assign fl_we_n_o = ~(s.act & s.we & (s.cnt != 4'h0));
endmodule : fws_bus_cycle

//--- logic/fws_ctrl.sv
// host controller that polls flash write-operation status over wishbone orders
// Behaviour
// RULE1: device toggle valid after final write strobe
// RULE2: device inverts sector toggle per erasing-sector read
// RULE3: combine sector and mode toggle flags
// RULE4: two back-to-back reads, compare toggle values
// RULE5: equal toggles means done, array readable
// RULE6: timing limit set: retest, else fail, reset
// RULE7: resume polling from the initial double read
// RULE8: device raises timing limit flag on overrun
// RULE9: device halts when programming one over zero
// RULE10: after timing-limit failure write reset command
// RULE11: erase window flag zero during acceptance time-out
// RULE12: skip window check if erases closely spaced
// RULE13: device ignores commands once window flag high
// RULE14: check window flag before and after erase
// RULE15: present valid address for status reads
// RULE16: status reads address the busy bank
// RULE17: device data-polling flag zero during erase
// RULE18: device mode toggle inverts during operation
// RULE19: device erase status pattern and busy low
`include "fws_cfg.svh"
module fws_ctrl #(
   parameter int AW = 23,
   parameter int DW = 16
) (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [3:0]    wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic [31:0]        wb_dat_o,
   output logic               wb_ack_o,
   output logic               irq_o,
   input  wire logic [DW-1:0] fl_dq_i,
   output logic [DW-1:0]      fl_dq_o,
   output logic               fl_dq_oe_o,
   output logic [AW-1:0]      fl_addr_o,
   output logic               fl_ce_n_o,
   output logic               fl_oe_n_o,
   output logic               fl_we_n_o,
   input  wire logic          ready_busy_in_i
);
   typedef struct packed {
      fws_pkg::fws_state_t st;
      logic [AW-1:0]       addr;
      logic [DW-1:0]       first;
      logic [DW-1:0]       last;
      logic                tlim_seen;
      logic                ewin_pre;
      logic                sector_erasing;
      logic                mode_active;
      logic                ack;
      logic [2:0]          stat;
      logic [2:0]          mask;
      logic                busy_flag;
      logic [31:0]         rdat;
   } fws_ctl_t;
   fws_ctl_t s, next_s;

   logic          cyc_start;
   logic          cyc_we;
   logic [DW-1:0] cyc_wdata;
   logic          cyc_busy;
   logic          cyc_done;
   logic [DW-1:0] cyc_rdata;
   logic          wb_req;
   logic [2:0]    ev;
   logic          rb1, rb2, rb3;
   logic [31:0]   rd_mux;

   fws_bus_cycle #(
      .AW (AW),
      .DW (DW)
   ) u_cyc (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .start_i    (cyc_start),
      .we_i       (cyc_we),
      .addr_i     (s.addr),
      .wdata_i    (cyc_wdata),
      .fl_dq_i    (fl_dq_i),
      .busy_o     (cyc_busy),
      .done_o     (cyc_done),
      .rdata_o    (cyc_rdata),
      .fl_addr_o  (fl_addr_o),
      .fl_dq_o    (fl_dq_o),
      .fl_dq_oe_o (fl_dq_oe_o),
      .fl_ce_n_o  (fl_ce_n_o),
      .fl_oe_n_o  (fl_oe_n_o),
      .fl_we_n_o  (fl_we_n_o)
   );

   // ready/busy pin is asynchronous: three stages, second and third agree
   always_ff @(posedge clk_i) begin
      rb1 <= ready_busy_in_i;
      rb2 <= rb1;
      rb3 <= rb2;
   end

   assign wb_req = wb_cyc_i & wb_stb_i & ~s.ack;

   always_comb begin
      cyc_start = 1'b0;
      cyc_we = 1'b0;
      cyc_wdata = '0;
      case (s.st)
         fws_pkg::FWS_RD1, fws_pkg::FWS_RD2, fws_pkg::FWS_RD3, fws_pkg::FWS_RD4,
         fws_pkg::FWS_EW1, fws_pkg::FWS_EW3: begin
            cyc_start = ~cyc_busy;
         end
         fws_pkg::FWS_RST: begin
            cyc_start = ~cyc_busy;
            cyc_we = 1'b1;
            cyc_wdata = `FWS_RST_CMD; // [RULE10]
         end
         fws_pkg::FWS_EW2: begin
            cyc_start = ~cyc_busy;
            cyc_we = 1'b1;
            cyc_wdata = s.first;
         end
         default: begin
            cyc_start = 1'b0;
         end
      endcase
   end

   always_comb begin
      next_s = s;
      ev = 3'h0;
      next_s.ack = wb_req;
      if (wb_req && !wb_we_i) next_s.rdat = rd_mux;
      if (rb2 == rb3) next_s.busy_flag = ~rb3;
      case (s.st)
         fws_pkg::FWS_IDLE: begin
            if (wb_req && wb_we_i && wb_adr_i[3:2] == `FWS_ADR_CTRL && wb_sel_i[0]) begin
               // every poll start begins with the double read, including resumes [RULE7]
               if (wb_dat_i[`FWS_CTRL_POLL]) next_s.st = fws_pkg::FWS_RD1;
               else if (wb_dat_i[`FWS_CTRL_RST]) next_s.st = fws_pkg::FWS_RST;
               // window check is optional when added erases come close together [RULE12]
               else if (wb_dat_i[`FWS_CTRL_ERSW]) next_s.st = fws_pkg::FWS_EW1;
            end
         end
         fws_pkg::FWS_RD1: begin
            if (cyc_done) begin
               next_s.first = cyc_rdata; // [RULE4]
               next_s.st = fws_pkg::FWS_RD2;
            end
         end
         fws_pkg::FWS_RD2: begin
            if (cyc_done) begin
               next_s.last = cyc_rdata;
               next_s.st = fws_pkg::FWS_CHK;
            end
         end
         fws_pkg::FWS_CHK: begin
            // both toggles read together give sector and mode [RULE3]
            next_s.sector_erasing = s.first[`FWS_BIT_STOG] ^ s.last[`FWS_BIT_STOG];
            next_s.mode_active = s.first[`FWS_BIT_MTOG] ^ s.last[`FWS_BIT_MTOG];
            if (s.first[`FWS_BIT_MTOG] == s.last[`FWS_BIT_MTOG]) begin
               ev[`FWS_EV_DONE] = 1'b1; // [RULE5]
               next_s.st = fws_pkg::FWS_IDLE;
            end else if (s.last[`FWS_BIT_TLIM]) begin
               // stays set until reset so software may look at it late
               next_s.tlim_seen = 1'b1;
               next_s.st = fws_pkg::FWS_RD3; // [RULE6]
            end else begin
               next_s.st = fws_pkg::FWS_IDLE; // software may repoll later
            end
         end
         fws_pkg::FWS_RD3: begin
            if (cyc_done) begin
               next_s.first = cyc_rdata;
               next_s.st = fws_pkg::FWS_RD4;
            end
         end
         fws_pkg::FWS_RD4: begin
            if (cyc_done) begin
               next_s.last = cyc_rdata;
               next_s.st = fws_pkg::FWS_CHK2;
            end
         end
         fws_pkg::FWS_CHK2: begin
            if (s.first[`FWS_BIT_MTOG] == s.last[`FWS_BIT_MTOG]) begin
               ev[`FWS_EV_DONE] = 1'b1; // [RULE6]
               next_s.st = fws_pkg::FWS_IDLE;
            end else begin
               ev[`FWS_EV_FAIL] = 1'b1; // [RULE6]
               next_s.st = fws_pkg::FWS_RST; // [RULE10]
            end
         end
         fws_pkg::FWS_RST: begin
            if (cyc_done) next_s.st = fws_pkg::FWS_IDLE;
         end
         fws_pkg::FWS_EW1: begin
            if (cyc_done) begin
               next_s.ewin_pre = cyc_rdata[`FWS_BIT_EWIN]; // [RULE14]
               next_s.st = fws_pkg::FWS_EW2;
            end
         end
         fws_pkg::FWS_EW2: begin
            if (cyc_done) next_s.st = fws_pkg::FWS_EW3;
         end
         fws_pkg::FWS_EW3: begin
            if (cyc_done) begin
               next_s.last = cyc_rdata;
               next_s.st = fws_pkg::FWS_EWCHK;
            end
         end
         fws_pkg::FWS_EWCHK: begin
            // high afterwards: the added sector may have been refused [RULE14]
            if (s.ewin_pre || s.last[`FWS_BIT_EWIN]) ev[`FWS_EV_REJ] = 1'b1;
            next_s.st = fws_pkg::FWS_IDLE;
         end
         default: begin
            next_s.st = fws_pkg::FWS_IDLE;
         end
      endcase
      if (wb_req && wb_we_i) begin
         if (wb_adr_i[3:2] == `FWS_ADR_ADDR && s.st == fws_pkg::FWS_IDLE) begin
            // address chosen by software must be in the busy bank [RULE15] [RULE16]
            next_s.addr = wb_dat_i[AW-1:0];
         end
         if (wb_adr_i[3:2] == `FWS_ADR_CTRL && s.st == fws_pkg::FWS_IDLE) begin
            next_s.first = wb_dat_i[DW+15:16];
         end
         if (wb_adr_i[3:2] == `FWS_ADR_MASK && wb_sel_i[0]) next_s.mask = wb_dat_i[2:0];
         if (wb_adr_i[3:2] == `FWS_ADR_STAT && wb_sel_i[0]) begin
            next_s.stat = s.stat & ~wb_dat_i[2:0];
         end
      end
      // new events win over a clear in the same cycle
      next_s.stat = next_s.stat | ev;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) s <= '0;
      else s <= next_s;
   end

   // read data is registered at the taking edge so it stands while ack is high
   always_comb begin
      rd_mux = 32'h0;
      case (wb_adr_i[3:2])
         `FWS_ADR_CTRL: rd_mux = {16'h0, 8'h0, s.busy_flag, s.tlim_seen, s.mode_active,
                                  s.sector_erasing, s.st};
         `FWS_ADR_ADDR: rd_mux = {{(32-AW){1'b0}}, s.addr};
         `FWS_ADR_STAT: rd_mux = {{(32-DW){1'b0}}, s.last} & 32'h0000FFFF |
                                 {13'h0, s.stat, 16'h0};
         `FWS_ADR_MASK: rd_mux = {29'h0, s.mask};
         default: rd_mux = 32'h0;
      endcase
   end
   assign wb_dat_o = s.rdat;
   assign wb_ack_o = s.ack;
   assign irq_o = |(s.stat & s.mask);

   property p_double_read;
      @(posedge clk_i) disable iff (rst_i)
         s.st == fws_pkg::FWS_RD1 && cyc_done |=> s.st == fws_pkg::FWS_RD2;
   endproperty
   a_double_read: assert property (p_double_read) else $error("no second read"); // [RULE4]
   property p_done;
      @(posedge clk_i) disable iff (rst_i)
         s.st == fws_pkg::FWS_CHK && s.first[`FWS_BIT_MTOG] == s.last[`FWS_BIT_MTOG]
         |=> s.stat[`FWS_EV_DONE];
   endproperty
   a_done: assert property (p_done) else $error("done not flagged"); // [RULE5]
   property p_fail;
      @(posedge clk_i) disable iff (rst_i)
         s.st == fws_pkg::FWS_CHK2 && s.first[`FWS_BIT_MTOG] != s.last[`FWS_BIT_MTOG]
         |=> s.stat[`FWS_EV_FAIL] && s.st == fws_pkg::FWS_RST;
   endproperty
   a_fail: assert property (p_fail) else $error("fail not handled"); // [RULE6]
   property p_retest;
      @(posedge clk_i) disable iff (rst_i)
         s.st == fws_pkg::FWS_CHK && s.first[`FWS_BIT_MTOG] != s.last[`FWS_BIT_MTOG]
         && s.last[`FWS_BIT_TLIM] |=> s.st == fws_pkg::FWS_RD3;
   endproperty
   a_retest: assert property (p_retest) else $error("no retest"); // [RULE6]
   property p_rst_cmd;
      @(posedge clk_i) disable iff (rst_i)
         s.st == fws_pkg::FWS_RST && cyc_start |-> cyc_we && cyc_wdata == `FWS_RST_CMD;
   endproperty
   a_rst_cmd: assert property (p_rst_cmd) else $error("bad reset cmd"); // [RULE10]
   property p_resume;
      @(posedge clk_i) disable iff (rst_i)
         $past(s.st) == fws_pkg::FWS_IDLE && s.st != fws_pkg::FWS_IDLE
         |-> s.st inside {fws_pkg::FWS_RD1, fws_pkg::FWS_RST, fws_pkg::FWS_EW1};
   endproperty
   a_resume: assert property (p_resume) else $error("bad restart"); // [RULE7]
   property p_reject;
      @(posedge clk_i) disable iff (rst_i)
         s.st == fws_pkg::FWS_EWCHK && s.last[`FWS_BIT_EWIN] |=> s.stat[`FWS_EV_REJ];
   endproperty
   a_reject: assert property (p_reject) else $error("reject missed"); // [RULE14]
   property p_addr_hold;
      @(posedge clk_i) disable iff (rst_i)
         s.st != fws_pkg::FWS_IDLE |=> $stable(s.addr);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("addr moved"); // [RULE15]
   property p_irq;
      @(posedge clk_i) disable iff (rst_i)
         |(s.stat & s.mask) |-> irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("irq low");
   c_done: cover property (@(posedge clk_i) s.st == fws_pkg::FWS_CHK ##1 s.stat[0]);
   c_fail: cover property (@(posedge clk_i) s.st == fws_pkg::FWS_CHK2 ##1 s.stat[1]);
   c_ersw: cover property (@(posedge clk_i) s.st == fws_pkg::FWS_EWCHK);
   c_retest: cover property (@(posedge clk_i)
      s.st == fws_pkg::FWS_CHK ##1 s.st == fws_pkg::FWS_RD3);
   c_quiet: cover property (@(posedge clk_i) s.mode_active && s.st == fws_pkg::FWS_IDLE);
   property p_quiet;
      @(posedge clk_i) disable iff (rst_i)
         s.st == fws_pkg::FWS_CHK && s.first[`FWS_BIT_MTOG] != s.last[`FWS_BIT_MTOG]
         && !s.last[`FWS_BIT_TLIM] |-> ev == 3'h0 ##1 s.st == fws_pkg::FWS_IDLE;
   endproperty
   a_quiet: assert property (p_quiet) else $error("busy without limit not idle"); // [RULE7]
   property p_flags;
      @(posedge clk_i) disable iff (rst_i)
         s.st == fws_pkg::FWS_CHK
         |=> s.sector_erasing == (s.first[`FWS_BIT_STOG] ^ s.last[`FWS_BIT_STOG])
         && s.mode_active == (s.first[`FWS_BIT_MTOG] ^ s.last[`FWS_BIT_MTOG]);
   endproperty
   a_flags: assert property (p_flags) else $error("toggle flags wrong"); // [RULE3]
   property p_ew_cmd;
      @(posedge clk_i) disable iff (rst_i)
         s.st == fws_pkg::FWS_EW2 && cyc_start |-> cyc_we && cyc_wdata == s.first;
   endproperty
   a_ew_cmd: assert property (p_ew_cmd) else $error("no command between checks"); // [RULE14]
   property p_addr_out;
      @(posedge clk_i) disable iff (rst_i)
         cyc_start |=> fl_addr_o == s.addr && !fl_ce_n_o;
   endproperty
   a_addr_out: assert property (p_addr_out) else $error("bad address"); // [RULE15] [RULE16]
   property p_ack_pulse;
      @(posedge clk_i) disable iff (rst_i)
         s.ack |=> !s.ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
endmodule : fws_ctrl

//--- tb/fws_flash_model.sv
// behavioural flash device answering status reads and command writes
module fws_flash_model #(
   parameter logic [15:0] ARRAY_WORD = 16'h5A21
) (
   input  wire logic [22:0] fl_addr_i,
   input  wire logic [15:0] fl_dq_i,
   input  wire logic        fl_ce_n_i,
   input  wire logic        fl_oe_n_i,
   input  wire logic        fl_we_n_i,
   output logic [15:0]      fl_dq_o,
   output logic             ready_busy_out_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int          tog_left;
   int          n_rd;
   int          n_wr;
   logic        tlim;
   logic        ewin;
   logic        ewin_after;
   logic        mtog;
   logic        stog;
   logic [15:0] last_q;
   logic [15:0] last_cmd;
   logic [22:0] rd_addr;
   wire         rd_act = !fl_ce_n_i && !fl_oe_n_i;
   wire         wr_act = !fl_ce_n_i && !fl_we_n_i;
   // busy pattern: polling 0, both toggles, limit, window
   wire  [15:0] stat = {8'h00, 1'b0, mtog, tlim, 1'b0, ewin, stog, 2'b00};
   initial begin
      tog_left = 0;
      tlim = 1'b0;
      ewin = 1'b0;
      ewin_after = 1'b0;
      mtog = 1'b0;
      stog = 1'b0;
      last_q = 16'h0000;
   end
   // a deselected bus shows the inverse of the last word, never a stale copy
   assign fl_dq_o = rd_act ? ((tog_left > 0) ? stat : ARRAY_WORD) : ~last_q;
   assign ready_busy_out_o = (tog_left == 0);
   always @(negedge rd_act) begin
      last_q = (tog_left > 0) ? stat : ARRAY_WORD;
      rd_addr = fl_addr_i;
      n_rd++;
      if (tog_left > 0) begin
         mtog = ~mtog;
         stog = ~stog;
         tog_left--;
      end
   end
   always @(negedge wr_act) begin
      last_cmd = fl_dq_i;
      n_wr++;
      if (fl_dq_i == 16'h00F0) begin
         tog_left = 0;
         tlim = 1'b0;
      end else begin
         ewin = ewin_after; // status valid from the write strobe end
      end
   end
endmodule : fws_flash_model

//--- tb/fws_ctrl_test.sv
// self-checking bench for the flash status-polling controller
`include "fws_cfg.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH %0t value differs", $time); end end
module fws_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i;
   logic        rst_i;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [3:0]  adr;
   logic [31:0] dat;
   logic [31:0] rd;
   wire  [31:0] wb_dat_o;
   wire         wb_ack_o;
   wire         irq_o;
   wire  [15:0] dq_in;
   wire  [15:0] dq_out;
   wire  [22:0] fl_addr;
   wire         ce_n;
   wire         oe_n;
   wire         we_n;
   wire         rdy;
   int          err_total;
   int          n_tests;
   int          cycles;
   int          r0;
   int          w0;
   fws_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .irq_o(irq_o), .fl_dq_i(dq_in), .fl_dq_o(dq_out),
      .fl_dq_oe_o(), .fl_addr_o(fl_addr), .fl_ce_n_o(ce_n), .fl_oe_n_o(oe_n),
      .fl_we_n_o(we_n), .ready_busy_in_i(rdy));
   fws_flash_model u_flash (.fl_addr_i(fl_addr), .fl_dq_i(dq_out), .fl_ce_n_i(ce_n),
      .fl_oe_n_i(oe_n), .fl_we_n_i(we_n), .fl_dq_o(dq_in), .ready_busy_out_o(rdy));
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   task complete_run;
      if (err_total == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run
   always @(posedge clk_i) begin
      cycles++;
      if (cycles > 30000) begin
         err_total++;
         complete_run();
      end
   end
   // one classic wishbone cycle; request held until ack is sampled high at a rising edge
   task wb(input logic w, input logic [1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {a, 2'b00};
      dat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) err_total++;
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb
   // start a poll and wait until the engine reports idle again
   task poll(input int tog, input logic lim);
      int k;
      u_flash.tog_left = tog;
      u_flash.tlim = lim;
      r0 = u_flash.n_rd;
      w0 = u_flash.n_wr;
      wb(1'b1, `FWS_ADR_ADDR, 32'h0012_3456);
      wb(1'b1, `FWS_ADR_CTRL, 32'h0000_0001);
      k = 0;
      do begin
         wb(1'b0, `FWS_ADR_CTRL, 32'h0);
         k++;
      end while (rd[3:0] !== 4'h0 && k < 300);
      if (k >= 300) err_total++;
      wb(1'b0, `FWS_ADR_STAT, 32'h0);
   endtask : poll
   task t_reset;
      wb(1'b0, `FWS_ADR_STAT, 32'h0);
      `CHK(rd[18:16], 3'h0)
      `CHK(irq_o, 1'b0)
   endtask : t_reset
   task t_done;
      poll(0, 1'b0);
      `CHK(rd[18:16], 3'h1)
      `CHK(u_flash.n_rd - r0, 2)
      `CHK(u_flash.rd_addr, 23'h12_3456)
      wb(1'b1, `FWS_ADR_MASK, 32'h1);
      `CHK(irq_o, 1'b1)
      wb(1'b1, `FWS_ADR_STAT, 32'h1);
      `CHK(irq_o, 1'b0)
   endtask : t_done
   task t_fail;
      // toggling stops at the retest: success, no reset command
      poll(2, 1'b1);
      `CHK(rd[18:16], 3'h1)
      `CHK(u_flash.n_rd - r0, 4)
      `CHK(u_flash.n_wr - w0, 0)
      wb(1'b1, `FWS_ADR_STAT, 32'h7);
      poll(1000, 1'b1);
      `CHK(rd[18:16], 3'h2)
      `CHK(u_flash.last_cmd, 16'h00F0)
      `CHK(u_flash.n_wr - w0, 1)
      wb(1'b1, `FWS_ADR_MASK, 32'h2);
      `CHK(irq_o, 1'b1)
      wb(1'b1, `FWS_ADR_STAT, 32'h7);
      `CHK(irq_o, 1'b0)
   endtask : t_fail
   task t_busy;
      poll(1000, 1'b0);
      `CHK(rd[18:16], 3'h0)
      `CHK(u_flash.n_rd - r0, 2)
      wb(1'b0, `FWS_ADR_CTRL, 32'h0);
      `CHK(rd[7], 1'b1)
      `CHK(rd[4], 1'b1)
      `CHK(rd[5], 1'b1)
      `CHK(rd[6], 1'b1)
      poll(0, 1'b0);
      `CHK(u_flash.n_rd - r0, 2)
      `CHK(rd[18:16], 3'h1)
      wb(1'b1, `FWS_ADR_STAT, 32'h7);
   endtask : t_busy
   task t_window(input logic after, input logic [2:0] ev);
      u_flash.tog_left = 1000;
      u_flash.ewin = 1'b0;
      u_flash.ewin_after = after;
      wb(1'b1, `FWS_ADR_MASK, 32'h4);
      wb(1'b1, `FWS_ADR_CTRL, 32'h0030_0004);
      repeat (80) @(posedge clk_i);
      wb(1'b0, `FWS_ADR_STAT, 32'h0);
      `CHK(rd[18:16], ev)
      `CHK(irq_o, ev[2])
      `CHK(u_flash.last_cmd, 16'h0030)
      wb(1'b1, `FWS_ADR_STAT, 32'h7);
      u_flash.tog_left = 0;
   endtask : t_window
   initial begin
      err_total = 0;
      n_tests = 0;
      cycles = 0;
      rst_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 4'h0;
      dat = 32'h0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_done();
      t_fail();
      t_busy();
      t_window(1'b1, 3'h4);
      t_window(1'b0, 3'h0);
      complete_run();
   end
endmodule : fws_ctrl_test
